//--- fic_host_model.sv
// host side model: watches the interrupt pin and times each pulse.
// assumes the bench tells it the programmed polarity.
`timescale 1ns/100ps
module fic_host (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic irq_pin,
   input  wire logic active_high,
   output int        n_pulse,
   output int        last_len
);
   logic on_q;
   int   run;
   wire  on = active_high ? irq_pin : !irq_pin;
   always @(posedge clk) begin
      on_q <= resetn & on;
      if (!resetn) begin
         n_pulse <= 0;
         last_len <= 0;
         run <= 0;
      end else if (on) begin
         run <= run + 1;
         if (!on_q) n_pulse <= n_pulse + 1;
      end else if (on_q) begin
         last_len <= run;
         run <= 0;
      end
   end
endmodule : fic_host

//--- fic_pkg.sv
// constants for the fault / interrupt configuration and status block.
// assumes an 8-bit register port and one 50 MHz clock.
package fic_pkg;
   // register offsets
   localparam logic [7:0] ADDR_RATIO_HIGH  = 8'h40;
   localparam logic [7:0] ADDR_RATIO_LOW   = 8'h41;
   localparam logic [7:0] ADDR_INT_CFG     = 8'h42;
   localparam logic [7:0] ADDR_DAC_CFG     = 8'h43;
   localparam logic [7:0] ADDR_MUTE_CFG    = 8'h4b;
   localparam logic [7:0] ADDR_LATCHED     = 8'h50;
   localparam logic [7:0] ADDR_MASK        = 8'h51;
   localparam logic [7:0] ADDR_LIVE        = 8'h52;
   localparam logic [7:0] ADDR_REPOWER     = 8'h53;

   // reset values
   localparam logic [7:0] RST_INT_CFG      = 8'h00;
   localparam logic [7:0] RST_DAC_CFG      = 8'h54;
   localparam logic [7:0] RST_MUTE_CFG     = 8'h00;
   localparam logic [7:0] RST_MASK         = 8'h00;

   // writable bits of each register; reserved bits read as zero
   localparam logic [7:0] WMASK_INT_CFG    = 8'hff;
   localparam logic [7:0] WMASK_DAC_CFG    = 8'h77;
   localparam logic [7:0] WMASK_MUTE_CFG   = 8'h18;

   // interrupt configuration fields
   localparam int INTERRUPT_POLARITY_BIT    = 7;
   localparam int INT_STYLE_HI   = 6;
   localparam int INT_STYLE_LO   = 5;
   localparam int ADC_PD_HI      = 4;
   localparam int ADC_PD_LO      = 3;
   localparam int READ_SEL_BIT   = 2;
   localparam int ADC_RCV_BIT    = 1;
   localparam int CLR_SEL_BIT    = 0;

   // dac fault configuration fields
   localparam int DAC_PD_HI      = 6;
   localparam int DAC_PD_LO      = 5;
   localparam int DAC_RCV_BIT    = 4;
   localparam int DAC_FLAG_BIT   = 3;
   localparam int PU_INHIBIT_BIT = 2;
   localparam int DAC_DET_DIS    = 1;
   localparam int REG_DET_DIS    = 0;

   // overload mute fields
   localparam int CH1_MUTE_BIT   = 4;
   localparam int CH2_MUTE_BIT   = 3;

   // re-power command bits
   localparam int REPOWER_ADC    = 0;
   localparam int REPOWER_DAC    = 1;

   // interrupt source positions
   localparam int NSRC           = 8;
   localparam logic [7:0] GRP_ADC_FAULT = 8'h07;
   localparam logic [7:0] GRP_DAC_FAULT = 8'h18;
   localparam logic [7:0] SRC_DRV_VG    = 8'h08;
   localparam logic [7:0] SRC_REG_SC    = 8'h20;

   typedef enum logic [1:0] {
      FIC_STYLE_LATCHED = 2'd0,
      FIC_STYLE_LIVE    = 2'd1,
      FIC_STYLE_REPEAT  = 2'd2,
      FIC_STYLE_ONESHOT = 2'd3
   } fic_style_t;

   typedef enum logic [1:0] {
      FIC_PD_OFF      = 2'd0,
      FIC_PD_UNMASKED = 2'd1,
      FIC_PD_ALL      = 2'd2,
      FIC_PD_RSVD     = 2'd3
   } fic_pd_t;

   // interrupt pulse timing
   localparam int CLK_HZ         = 50_000_000;
   localparam int PULSE_MS       = 2;
   localparam int PERIOD_MS      = 4;
   localparam int PULSE_CYCLES   = CLK_HZ / 1000 * PULSE_MS;
   localparam int PERIOD_CYCLES  = CLK_HZ / 1000 * PERIOD_MS;
   localparam int CNT_W          = 24;
endpackage : fic_pkg

//--- fic_top.sv
// fault and interrupt configuration, latched status and fault power-down.
// assumes ratio, recovery and power-up inputs come from logic on clk;
// fault/interrupt live sources are asynchronous and are synchronised here.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
module fic_top #(
   parameter int PULSE_CNT  = fic_pkg::PULSE_CYCLES,
   parameter int PERIOD_CNT = fic_pkg::PERIOD_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic [13:0] ratio_value,
   input  wire logic [7:0]  source_live,
   input  wire logic        dac_powering_up,
   input  wire logic        adc1_overload_recovery,
   input  wire logic        adc2_overload_recovery,
   output logic             interrupt_out,
   output logic             adc_micbias_powerdown,
   output logic             dac_powerdown,
   output logic             adc1_mute,
   output logic             adc2_mute
);

   typedef struct packed {
      logic [7:0]                  int_cfg;
      logic [7:0]                  dac_cfg;
      logic [7:0]                  mute_cfg;
      logic [7:0]                  mask;
      logic [7:0]                  latched;
      logic [7:0]                  live_s1;
      logic [7:0]                  live_s2;
      logic [7:0]                  live_prev;
      logic                        adc_pd;
      logic                        dac_pd;
      logic [fic_pkg::CNT_W-1:0]   period_cnt;
      logic [fic_pkg::CNT_W-1:0]   shot_cnt;
      logic [7:0]                  rdata;
      logic                        irq;
      logic                        mute1;
      logic                        mute2;
   } fic_state_t;

   fic_state_t q;
   fic_state_t d;

   localparam logic [fic_pkg::CNT_W-1:0] PULSE_LEN  =
      fic_pkg::CNT_W'(PULSE_CNT);
   localparam logic [fic_pkg::CNT_W-1:0] PERIOD_LEN =
      fic_pkg::CNT_W'(PERIOD_CNT);

   logic [7:0]          live_f;
   logic [7:0]          unmasked;
   logic [7:0]          new_evt;
   logic [7:0]          shown;
   logic [7:0]          clr;
   logic [7:0]          adc_flt;
   logic [7:0]          dac_flt;
   logic                adc_fault;
   logic                dac_fault;
   logic                irq_act;
   logic                rd_latched;
   fic_pkg::fic_style_t style;
   fic_pkg::fic_pd_t    adc_mode;
   fic_pkg::fic_pd_t    dac_mode;

   always_comb begin
      d = q;
      style    = fic_pkg::fic_style_t'(q.int_cfg[fic_pkg::INT_STYLE_HI:
                                                 fic_pkg::INT_STYLE_LO]);
      adc_mode = fic_pkg::fic_pd_t'(q.int_cfg[fic_pkg::ADC_PD_HI:
                                              fic_pkg::ADC_PD_LO]);
      dac_mode = fic_pkg::fic_pd_t'(q.dac_cfg[fic_pkg::DAC_PD_HI:
                                              fic_pkg::DAC_PD_LO]);

      // synchroniser; only live_s2 feeds logic
      d.live_s1   = source_live;
      d.live_s2   = q.live_s1;

      // detection disables gate the sources before anything sees them
      live_f = q.live_s2;
      if (q.dac_cfg[fic_pkg::DAC_DET_DIS]) begin
         live_f = live_f & ~fic_pkg::GRP_DAC_FAULT;
      end
      if (q.dac_cfg[fic_pkg::REG_DET_DIS]) begin
         live_f = live_f & ~fic_pkg::SRC_REG_SC;
      end
      d.live_prev = live_f;
      unmasked    = ~q.mask;
      new_evt     = live_f & ~q.live_prev;

      // latched readback view and clear-on-read
      shown = q.int_cfg[fic_pkg::READ_SEL_BIT] ?
              (q.latched & unmasked) : q.latched;
      rd_latched = reg_rd && (reg_addr == fic_pkg::ADDR_LATCHED);
      clr = 8'h00;
      if (rd_latched) begin
         clr = q.int_cfg[fic_pkg::CLR_SEL_BIT] ?
               shown : (shown & ~live_f);
      end
      // a new event in the clearing cycle survives
      d.latched = (q.latched & ~clr) | new_evt;

      // fault selection per power-down mode
      case (adc_mode)
         fic_pkg::FIC_PD_UNMASKED: adc_flt = live_f & unmasked;
         fic_pkg::FIC_PD_ALL:      adc_flt = live_f;
         default:                  adc_flt = 8'h00;
      endcase
      case (dac_mode)
         fic_pkg::FIC_PD_UNMASKED: dac_flt = live_f & unmasked;
         fic_pkg::FIC_PD_ALL:      dac_flt = live_f;
         default:                  dac_flt = 8'h00;
      endcase
      if (dac_powering_up && q.dac_cfg[fic_pkg::PU_INHIBIT_BIT]) begin
         dac_flt = dac_flt & ~fic_pkg::SRC_DRV_VG;
      end
      adc_fault = |(adc_flt & fic_pkg::GRP_ADC_FAULT);
      dac_fault = |(dac_flt & fic_pkg::GRP_DAC_FAULT);

      // power-down with auto or manual recovery; fault wins over re-power
      if (!q.int_cfg[fic_pkg::ADC_RCV_BIT]) begin
         d.adc_pd = adc_fault;
      end else begin
         d.adc_pd = q.adc_pd;
         if (reg_wr && reg_addr == fic_pkg::ADDR_REPOWER &&
             reg_wdata[fic_pkg::REPOWER_ADC]) begin
            d.adc_pd = 1'b0;
         end
         d.adc_pd = d.adc_pd | adc_fault;
      end
      if (!q.dac_cfg[fic_pkg::DAC_RCV_BIT]) begin
         d.dac_pd = dac_fault;
      end else begin
         d.dac_pd = q.dac_pd;
         if (reg_wr && reg_addr == fic_pkg::ADDR_REPOWER &&
             reg_wdata[fic_pkg::REPOWER_DAC]) begin
            d.dac_pd = 1'b0;
         end
         d.dac_pd = d.dac_pd | dac_fault;
      end

      // repeat timer runs only while something is pending
      if (|(q.latched & unmasked)) begin
         d.period_cnt = (q.period_cnt >= PERIOD_LEN - 1'b1) ?
                        '0 : q.period_cnt + 1'b1;
      end else begin
         d.period_cnt = '0;
      end
      // one-shot restarts on each unmasked event
      if (|(new_evt & unmasked)) begin
         d.shot_cnt = PULSE_LEN;
      end else if (q.shot_cnt != '0) begin
         d.shot_cnt = q.shot_cnt - 1'b1;
      end

      case (style)
         fic_pkg::FIC_STYLE_LATCHED:
            irq_act = |(q.latched & unmasked);
         fic_pkg::FIC_STYLE_LIVE:
            irq_act = |(live_f & unmasked);
         fic_pkg::FIC_STYLE_REPEAT:
            irq_act = |(q.latched & unmasked) &&
                      (q.period_cnt < PULSE_LEN);
         fic_pkg::FIC_STYLE_ONESHOT:
            irq_act = (q.shot_cnt != '0);
         default:
            irq_act = 1'b0;
      endcase
      d.irq = q.int_cfg[fic_pkg::INTERRUPT_POLARITY_BIT] ? irq_act : ~irq_act;

      d.mute1 = q.mute_cfg[fic_pkg::CH1_MUTE_BIT] &&
                adc1_overload_recovery;
      d.mute2 = q.mute_cfg[fic_pkg::CH2_MUTE_BIT] &&
                adc2_overload_recovery;

      // writes; reserved bits are dropped, so stray ones do no harm
      if (reg_wr) begin
         case (reg_addr)
            fic_pkg::ADDR_INT_CFG:
               d.int_cfg = reg_wdata & fic_pkg::WMASK_INT_CFG;
            fic_pkg::ADDR_DAC_CFG:
               d.dac_cfg = reg_wdata & fic_pkg::WMASK_DAC_CFG;
            fic_pkg::ADDR_MUTE_CFG:
               d.mute_cfg = reg_wdata & fic_pkg::WMASK_MUTE_CFG;
            fic_pkg::ADDR_MASK:
               d.mask = reg_wdata;
            default: ;
         endcase
      end

      // read data stand for one cycle only
      d.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            fic_pkg::ADDR_RATIO_HIGH:
               d.rdata = {2'b00, ratio_value[13:8]};
            fic_pkg::ADDR_RATIO_LOW:
               d.rdata = ratio_value[7:0];
            fic_pkg::ADDR_INT_CFG:
               d.rdata = q.int_cfg;
            fic_pkg::ADDR_DAC_CFG: begin
               d.rdata = q.dac_cfg;
               d.rdata[fic_pkg::DAC_FLAG_BIT] = q.dac_pd;
            end
            fic_pkg::ADDR_MUTE_CFG:
               d.rdata = q.mute_cfg;
            fic_pkg::ADDR_LATCHED:
               d.rdata = shown;
            fic_pkg::ADDR_MASK:
               d.rdata = q.mask;
            fic_pkg::ADDR_LIVE:
               d.rdata = live_f;
            default:
               d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         q            <= '0;
         q.int_cfg    <= fic_pkg::RST_INT_CFG;
         q.dac_cfg    <= fic_pkg::RST_DAC_CFG;
         q.mute_cfg   <= fic_pkg::RST_MUTE_CFG;
         q.mask       <= fic_pkg::RST_MASK;
         q.irq        <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata             = q.rdata;
   assign interrupt_out         = q.irq;
   assign adc_micbias_powerdown = q.adc_pd;
   assign dac_powerdown         = q.dac_pd;
   assign adc1_mute             = q.mute1;
   assign adc2_mute             = q.mute2;

endmodule : fic_top

//--- fic_top_asserts.sv
// checker for fic_top; sees its ports only.
// assumes config changes only through observed register writes.
`timescale 1ns/100ps
module fic_chk (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic [13:0] ratio_value,
   input wire logic [7:0]  source_live,
   input wire logic        adc1_overload_recovery,
   input wire logic        interrupt_out,
   input wire logic        adc_micbias_powerdown,
   input wire logic        dac_powerdown,
   input wire logic        adc1_mute,
   input wire logic        adc2_mute
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [7:0]  ic_q, dc_q, mc_q, mk_q;
   logic [13:0] rv_q;
   // shadows track writes so checks need no view of the body
   always_ff @(posedge clk) begin
      rv_q <= ratio_value;
      if (!resetn) begin
         ic_q <= 8'h00;
         dc_q <= 8'h54;
         mc_q <= 8'h00;
         mk_q <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == 8'h42) ic_q <= reg_wdata;
         if (reg_addr == 8'h43) dc_q <= reg_wdata & 8'h77;
         if (reg_addr == 8'h4b) mc_q <= reg_wdata & 8'h18;
         if (reg_addr == 8'h51) mk_q <= reg_wdata;
      end
   end
   property p_ratio_hi;
      reg_rd && reg_addr == 8'h40 |=> reg_rdata == {2'b00, rv_q[13:8]};
   endproperty
   a_ratio_hi: assert property (p_ratio_hi)
      else $error("ratio upper byte wrong");
   property p_ratio_lo;
      reg_rd && reg_addr == 8'h41 |=> reg_rdata == rv_q[7:0];
   endproperty
   a_ratio_lo: assert property (p_ratio_lo)
      else $error("ratio lower byte wrong");
   property p_dac_rd;
      reg_rd && reg_addr == 8'h43 |=> (reg_rdata & 8'hf7) == dc_q;
   endproperty
   a_dac_rd: assert property (p_dac_rd)
      else $error("dac config readback wrong");
   property p_flag;
      reg_rd && reg_addr == 8'h43 |=> reg_rdata[3] == $past(dac_powerdown);
   endproperty
   a_flag: assert property (p_flag)
      else $error("dac down flag wrong");
   property p_mute1;
      mc_q[4] && adc1_overload_recovery |=> adc1_mute;
   endproperty
   a_mute1: assert property (p_mute1)
      else $error("channel 1 not muted");
   property p_mute2;
      !mc_q[3] |=> !adc2_mute;
   endproperty
   a_mute2: assert property (p_mute2)
      else $error("channel 2 muted while disabled");
   // live style: 4 quiet cycles cover sync plus output register
   property p_live_on;
      (ic_q[6:5] == 2'd1 && !mk_q[6] && !reg_wr && source_live[6])[*4]
         |=> interrupt_out == ic_q[7];
   endproperty
   a_live_on: assert property (p_live_on)
      else $error("live interrupt not asserted");
   property p_live_off;
      (ic_q[6:5] == 2'd1 && !reg_wr && source_live == 8'h00)[*4]
         |=> interrupt_out == !ic_q[7];
   endproperty
   a_live_off: assert property (p_live_off)
      else $error("idle interrupt level wrong");
   property p_adc_pd;
      (ic_q[4:3] == 2'd2 && !reg_wr && source_live[0])[*4]
         |=> adc_micbias_powerdown;
   endproperty
   a_adc_pd: assert property (p_adc_pd)
      else $error("adc not powered down");
   property p_adc_rcv;
      (!ic_q[1] && !reg_wr && source_live[2:0] == 3'b000)[*5]
         |=> !adc_micbias_powerdown;
   endproperty
   a_adc_rcv: assert property (p_adc_rcv)
      else $error("adc not re-powered");
   property p_dac_pd;
      (dc_q[6:5] == 2'd2 && !dc_q[1] && !reg_wr && source_live[4])[*4]
         |=> dac_powerdown;
   endproperty
   a_dac_pd: assert property (p_dac_pd)
      else $error("dac not powered down");
endmodule : fic_chk

//--- tb_top.sv
// testbench for fic_top: register port tasks and directed sequences.
// assumes short pulse counts of 4 and 8 cycles.
`timescale 1ns/100ps
module tb_top;
   localparam int PC = 4;
   localparam int PP = 8;
   logic        clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [13:0] ratio_value = 14'h2a5c;
   logic [7:0]  source_live = 8'h00;
   logic        dac_powering_up = 1'b0, pol = 1'b0;
   logic        adc1_overload_recovery = 1'b0, adc2_overload_recovery = 1'b0;
   logic        interrupt_out, adc_micbias_powerdown, dac_powerdown;
   logic        adc1_mute, adc2_mute;
   int          n_pulse, last_len, p0, err_total = 0, n_compared = 0;
   always #10 clk = ~clk;
   fic_top #(.PULSE_CNT(PC), .PERIOD_CNT(PP)) fic_top_inst (.clk(clk),
      .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ratio_value(ratio_value), .source_live(source_live),
      .dac_powering_up(dac_powering_up),
      .adc1_overload_recovery(adc1_overload_recovery),
      .adc2_overload_recovery(adc2_overload_recovery),
      .interrupt_out(interrupt_out),
      .adc_micbias_powerdown(adc_micbias_powerdown),
      .dac_powerdown(dac_powerdown), .adc1_mute(adc1_mute),
      .adc2_mute(adc2_mute));
   fic_host fic_host_inst (.clk(clk), .resetn(resetn), .irq_pin(interrupt_out),
      .active_high(pol), .n_pulse(n_pulse), .last_len(last_len));
   task automatic end_sim;
      if (err_total == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cb(input string nm, input logic e, input logic g);
      chk(nm, {7'h00, e}, {7'h00, g});
   endtask : cb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", e, reg_rdata);
   endtask : rd
   task automatic src(input logic [7:0] v);
      @(posedge clk);
      source_live <= v;
   endtask : src
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // interrupt level worked out from the programmed polarity
   task automatic irq(input logic on);
      cb("interrupt_out", on ~^ pol, interrupt_out);
   endtask : irq
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_sim();
   end
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      rd(8'h42, 8'h00);
      rd(8'h43, 8'h54);
      rd(8'h60, 8'h00);
      rd(8'h40, 8'h2a);
      rd(8'h41, 8'h5c);
      wr(8'h4b, 8'hff);
      rd(8'h4b, 8'h18);
      @(posedge clk);
      adc1_overload_recovery <= 1'b1;
      adc2_overload_recovery <= 1'b1;
      step(3);
      cb("adc1_mute", 1'b1, adc1_mute);
      cb("adc2_mute", 1'b1, adc2_mute);
      wr(8'h4b, 8'h08);
      step(2);
      cb("adc1_mute", 1'b0, adc1_mute);
      cb("adc2_mute", 1'b1, adc2_mute);
      wr(8'h42, 8'h20);
      src(8'h40);
      step(6);
      irq(1'b1);
      src(8'h00);
      step(6);
      irq(1'b0);
      wr(8'h42, 8'ha0);
      pol <= 1'b1;
      step(3);
      irq(1'b0);
      src(8'h40);
      step(6);
      irq(1'b1);
      src(8'h00);
      wr(8'h42, 8'h00);
      pol <= 1'b0;
      step(3);
      irq(1'b1);
      rd(8'h50, 8'h40);
      rd(8'h50, 8'h00);
      step(3);
      irq(1'b0);
      src(8'h40);
      step(5);
      rd(8'h50, 8'h40);
      rd(8'h50, 8'h40);
      wr(8'h51, 8'h40);
      step(3);
      irq(1'b0);
      wr(8'h42, 8'h04);
      rd(8'h50, 8'h00);
      wr(8'h42, 8'h01);
      rd(8'h50, 8'h40);
      rd(8'h50, 8'h00);
      src(8'h00);
      wr(8'h51, 8'h00);
      wr(8'h42, 8'h60);
      p0 = n_pulse;
      src(8'h80);
      src(8'h00);
      step(12);
      chk("pulses", 8'h01, 8'(n_pulse - p0));
      chk("pulse_len", 8'(PC), 8'(last_len));
      wr(8'h42, 8'h40);
      p0 = n_pulse;
      step(3 * PP);
      cb("repeating", 1'b1, (n_pulse - p0) >= 2);
      chk("pulse_len", 8'(PC), 8'(last_len));
      rd(8'h50, 8'h80);
      step(PP);
      p0 = n_pulse;
      step(2 * PP);
      chk("pulses", 8'h00, 8'(n_pulse - p0));
      wr(8'h51, 8'h01);
      src(8'h01);
      for (int m = 0; m < 4; m++) begin
         wr(8'h42, 8'(m << 3));
         step(4);
         cb("adc_pd", m == 2, adc_micbias_powerdown);
      end
      wr(8'h51, 8'h00);
      wr(8'h42, 8'h08);
      step(4);
      cb("adc_pd", 1'b1, adc_micbias_powerdown);
      src(8'h00);
      step(5);
      cb("adc_pd", 1'b0, adc_micbias_powerdown);
      wr(8'h42, 8'h12);
      src(8'h01);
      step(5);
      src(8'h00);
      step(5);
      cb("adc_pd", 1'b1, adc_micbias_powerdown);
      wr(8'h53, 8'h01);
      step(3);
      cb("adc_pd", 1'b0, adc_micbias_powerdown);
      src(8'h10);
      step(5);
      cb("dac_pd", 1'b1, dac_powerdown);
      rd(8'h43, 8'h5c);
      src(8'h00);
      step(5);
      cb("dac_pd", 1'b1, dac_powerdown);
      wr(8'h53, 8'h02);
      step(3);
      cb("dac_pd", 1'b0, dac_powerdown);
      rd(8'h43, 8'h54);
      wr(8'h43, 8'h42);
      src(8'h10);
      step(5);
      cb("dac_pd", 1'b0, dac_powerdown);
      wr(8'h43, 8'h44);
      @(posedge clk);
      dac_powering_up <= 1'b1;
      src(8'h08);
      step(5);
      cb("dac_pd", 1'b0, dac_powerdown);
      wr(8'h43, 8'h40);
      step(4);
      cb("dac_pd", 1'b1, dac_powerdown);
      src(8'h00);
      step(5);
      cb("dac_pd", 1'b0, dac_powerdown);
      wr(8'h43, 8'h41);
      wr(8'h42, 8'h20);
      src(8'h20);
      step(6);
      irq(1'b0);
      wr(8'h43, 8'h40);
      step(6);
      irq(1'b1);
      // every dac mode, the dac short masked so unmasked mode ignores it
      wr(8'h51, 8'h10);
      src(8'h10);
      for (int m = 0; m < 4; m++) begin
         wr(8'h43, 8'(m << 5));
         step(4);
         cb("dac_pd", m == 2, dac_powerdown);
      end
      end_sim();
   end
endmodule : tb_top
bind fic_top fic_chk fic_chk_inst (.clk(clk), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ratio_value(ratio_value),
   .source_live(source_live), .adc1_overload_recovery(adc1_overload_recovery),
   .interrupt_out(interrupt_out), .adc_micbias_powerdown(adc_micbias_powerdown),
   .dac_powerdown(dac_powerdown), .adc1_mute(adc1_mute), .adc2_mute(adc2_mute));
